// file: core/iox_pkg.sv
// Types shared by the I/O expander design.
package iox_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  // One bit per pin: a is the open-drain group, b the push-pull group.
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
  } iox_port_t;

  // Serial interface states, one-hot.
  typedef enum logic [6:0] {
    IOX_IDLE = 7'b0000001,
    IOX_ADDR = 7'b0000010,
    IOX_ACK  = 7'b0000100,
    IOX_WRX  = 7'b0001000,
    IOX_TX   = 7'b0010000,
    IOX_MACK = 7'b0100000,
    IOX_SKIP = 7'b1000000
  } iox_state_t;

endpackage : iox_pkg

// file: core/iox_regs.svh
// Register offsets, reset values and bus constants of the 16-bit I/O expander.
`ifndef IOX_REGS_SVH
`define IOX_REGS_SVH

// ----------------------------------------------------------------------------
// Register selectors
// ----------------------------------------------------------------------------
`define IOX_CMD_IN_A 8'h00
`define IOX_CMD_IN_B 8'h01
`define IOX_CMD_OUT_A 8'h02
`define IOX_CMD_OUT_B 8'h03
`define IOX_CMD_DIR_A 8'h04
`define IOX_CMD_DIR_B 8'h05
`define IOX_CMD_MASK_A 8'h06
`define IOX_CMD_MASK_B 8'h07

// ----------------------------------------------------------------------------
// Reset values and bus constants
// ----------------------------------------------------------------------------
`define IOX_DIR_RST 8'h00
`define IOX_MASK_RST 8'h00
`define IOX_OUT_RST 8'h00
`define IOX_NIB_HIGH 4'hf
`define IOX_NIB_LOW 4'h0
`define IOX_ADDR_HI 5'h16
`define IOX_BIT_CNT_BYTE 4'h8
`define IOX_BIT_CNT_LAST 4'h7
`define IOX_STRAP_WAIT 3'h5
`define IOX_SYNC_RST 21'h1c0000

`endif

// file: core/iox_sync.sv
// Three-stage input synchroniser with an agreement filter.
`timescale 1ns/10ps
module iox_sync #(
  parameter int W = 21,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Raw and filtered levels.
  input wire logic [W-1:0] raw_in,
  output logic [W-1:0] filt_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] filt_nxt;

  // A level is accepted once the second and third stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      assign filt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_out[gi];
    end
  endgenerate

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      filt_out <= RST_VAL;
    end
    else
    begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_out <= filt_nxt;
    end
  end

endmodule : iox_sync

// file: core/iox_top.sv
// Serial-bus 16-bit I/O expander with latched transition detection.
`timescale 1ns/10ps
`include "iox_regs.svh"
module iox_top
  import iox_pkg::*;
(
  // Clock and power-on reset.
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Serial bus.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Bus reset and address select straps.
  input wire logic bus_reset_n_in,
  input wire logic addr_sel_0_in,
  input wire logic addr_sel_1_in,
  // Open-drain pin group.
  input wire logic [7:0] drain_group_pins_in,
  output logic [7:0] drain_group_pins_out,
  output logic [7:0] drain_group_pins_oe_out,
  // Push-pull pin group.
  input wire logic [7:0] drive_group_pins_in,
  output logic [7:0] drive_group_pins_out,
  output logic [7:0] drive_group_pins_oe_out,
  // Interrupt and standby.
  output logic interrupt_out_n_out,
  output logic interrupt_oe_out,
  output logic standby_out
);

  // --------------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------------
  localparam int SW = 21;
  logic [SW-1:0] raw;
  logic [SW-1:0] filt;
  logic scl_s;
  logic sda_s;
  logic brst_n_s;
  logic as1_s;
  logic as0_s;
  iox_port_t pins;

  // Every pin passes the filtered three-stage synchroniser.
  assign raw = {scl_in, sda_in, bus_reset_n_in, addr_sel_1_in, addr_sel_0_in,
                drain_group_pins_in, drive_group_pins_in};

  iox_sync #(
    .W(SW),
    .RST_VAL(`IOX_SYNC_RST)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .raw_in(raw),
    .filt_out(filt)
  );

  // Unpack the filtered levels.
  assign scl_s = filt[20];
  assign sda_s = filt[19];
  assign brst_n_s = filt[18];
  assign as1_s = filt[17];
  assign as0_s = filt[16];
  assign pins = filt[15:0];

  // --------------------------------------------------------------------------
  // Serial interface and register file
  // --------------------------------------------------------------------------
  iox_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic rw_r, rw_nxt;
  logic addr_ph_r, addr_ph_nxt;
  logic cmd_ph_r, cmd_ph_nxt;
  logic sda_drv_r, sda_drv_nxt;
  logic scl_q_r, scl_q_nxt;
  logic sda_q_r, sda_q_nxt;
  iox_port_t out_r, out_nxt;
  iox_port_t dir_r, dir_nxt;
  iox_port_t mask_r, mask_nxt;
  logic [2:0] strap_cnt_r, strap_cnt_nxt;
  logic strap_done_r, strap_done_nxt;
  logic [1:0] rd_clr;
  logic [7:0] rd_val;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_hit;

  // Returns the byte that a read of the selected register presents.
  function automatic logic [7:0] rd_byte(input logic [7:0] cmd, input iox_port_t snap,
                                         input iox_port_t o, input iox_port_t d,
                                         input iox_port_t m);
    case (cmd)
      `IOX_CMD_IN_A: rd_byte = snap.a;
      `IOX_CMD_IN_B: rd_byte = snap.b;
      `IOX_CMD_OUT_A: rd_byte = o.a;
      `IOX_CMD_OUT_B: rd_byte = o.b;
      `IOX_CMD_DIR_A: rd_byte = d.a;
      `IOX_CMD_DIR_B: rd_byte = d.b;
      `IOX_CMD_MASK_A: rd_byte = m.a;
      `IOX_CMD_MASK_B: rd_byte = m.b;
      default: rd_byte = 8'h00;
    endcase
  endfunction : rd_byte

  // Bus conditions seen on the filtered lines.
  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_det = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign addr_hit = (shift_r[7:1] == {`IOX_ADDR_HI, as1_s, as0_s});
  assign rd_val = rd_byte(cmd_r, pins, out_r, dir_r, mask_r);

  // Next state of the serial engine, the registers and the power-up straps.
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    cmd_nxt = cmd_r;
    rw_nxt = rw_r;
    addr_ph_nxt = addr_ph_r;
    cmd_ph_nxt = cmd_ph_r;
    sda_drv_nxt = sda_drv_r;
    scl_q_nxt = scl_s;
    sda_q_nxt = sda_s;
    out_nxt = out_r;
    dir_nxt = dir_r;
    mask_nxt = mask_r;
    strap_cnt_nxt = strap_cnt_r;
    strap_done_nxt = strap_done_r;
    rd_clr = 2'b00;
    if (!strap_done_r)
    begin
      // Wait for the straps to pass the synchroniser, then load the defaults.
      strap_cnt_nxt = strap_cnt_r + 3'h1;
      if (strap_cnt_r == `IOX_STRAP_WAIT)
      begin
        strap_done_nxt = 1'b1;
        out_nxt.a = {as1_s ? `IOX_NIB_HIGH : `IOX_NIB_LOW,
                     as0_s ? `IOX_NIB_HIGH : `IOX_NIB_LOW};
        out_nxt.b = {as1_s ? `IOX_NIB_HIGH : `IOX_NIB_LOW,
                     as0_s ? `IOX_NIB_HIGH : `IOX_NIB_LOW};
      end
    end
    else if (!brst_n_s)
    begin
      state_nxt = IOX_IDLE;
      sda_drv_nxt = 1'b0;
    end
    else if (start_det)
    begin
      state_nxt = IOX_ADDR;
      cnt_nxt = 4'h0;
      sda_drv_nxt = 1'b0;
    end
    else if (stop_det)
    begin
      state_nxt = IOX_IDLE;
      sda_drv_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        IOX_ADDR, IOX_WRX:
        begin
          if (scl_rise)
          begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (scl_fall && cnt_r == `IOX_BIT_CNT_BYTE)
          begin
            cnt_nxt = 4'h0;
            if (state_r == IOX_ADDR)
            begin
              if (addr_hit)
              begin
                state_nxt = IOX_ACK;
                sda_drv_nxt = 1'b1;
                addr_ph_nxt = 1'b1;
                rw_nxt = shift_r[0];
                cmd_ph_nxt = ~shift_r[0];
                if (shift_r[0])
                begin
                  shift_nxt = rd_val;
                  rd_clr[0] = (cmd_r == `IOX_CMD_IN_A);
                  rd_clr[1] = (cmd_r == `IOX_CMD_IN_B);
                end
              end
              else
              begin
                state_nxt = IOX_SKIP;
              end
            end
            else
            begin
              state_nxt = IOX_ACK;
              sda_drv_nxt = 1'b1;
              if (cmd_ph_r)
              begin
                cmd_nxt = shift_r;
                cmd_ph_nxt = 1'b0;
              end
              else
              begin
                case (cmd_r)
                  `IOX_CMD_OUT_A: out_nxt.a = shift_r;
                  `IOX_CMD_OUT_B: out_nxt.b = shift_r;
                  `IOX_CMD_DIR_A: dir_nxt.a = shift_r;
                  `IOX_CMD_DIR_B: dir_nxt.b = shift_r;
                  `IOX_CMD_MASK_A: mask_nxt.a = shift_r;
                  `IOX_CMD_MASK_B: mask_nxt.b = shift_r;
                  default: cmd_nxt = cmd_r;
                endcase
              end
            end
          end
        end
        IOX_ACK:
        begin
          // The acknowledge ends on the falling edge of the ninth clock.
          if (scl_fall)
          begin
            addr_ph_nxt = 1'b0;
            if (addr_ph_r && rw_r)
            begin
              state_nxt = IOX_TX;
              sda_drv_nxt = ~shift_r[7];
            end
            else
            begin
              state_nxt = IOX_WRX;
              sda_drv_nxt = 1'b0;
            end
          end
        end
        IOX_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_r == `IOX_BIT_CNT_LAST)
            begin
              state_nxt = IOX_MACK;
              sda_drv_nxt = 1'b0;
              cnt_nxt = 4'h0;
            end
            else
            begin
              shift_nxt = {shift_r[6:0], 1'b0};
              sda_drv_nxt = ~shift_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        IOX_MACK:
        begin
          // A high acknowledge bit from the master ends the read.
          if (scl_rise && sda_s)
          begin
            state_nxt = IOX_SKIP;
          end
          else if (scl_fall)
          begin
            state_nxt = IOX_TX;
            shift_nxt = rd_val;
            sda_drv_nxt = ~rd_val[7];
          end
        end
        IOX_IDLE, IOX_SKIP:
        begin
          sda_drv_nxt = 1'b0;
        end
        default:
        begin
          state_nxt = IOX_IDLE;
          sda_drv_nxt = 1'b0;
        end
      endcase
    end
  end

  // Registers of the serial engine and the register file.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_r <= IOX_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      cmd_r <= `IOX_CMD_IN_A;
      rw_r <= 1'b0;
      addr_ph_r <= 1'b0;
      cmd_ph_r <= 1'b0;
      sda_drv_r <= 1'b0;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      out_r <= {`IOX_OUT_RST, `IOX_OUT_RST};
      dir_r <= {`IOX_DIR_RST, `IOX_DIR_RST};
      mask_r <= {`IOX_MASK_RST, `IOX_MASK_RST};
      strap_cnt_r <= 3'h0;
      strap_done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      cmd_r <= cmd_nxt;
      rw_r <= rw_nxt;
      addr_ph_r <= addr_ph_nxt;
      cmd_ph_r <= cmd_ph_nxt;
      sda_drv_r <= sda_drv_nxt;
      scl_q_r <= scl_q_nxt;
      sda_q_r <= sda_q_nxt;
      out_r <= out_nxt;
      dir_r <= dir_nxt;
      mask_r <= mask_nxt;
      strap_cnt_r <= strap_cnt_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Transition detection
  // --------------------------------------------------------------------------
  logic [15:0] ref_r, ref_nxt;
  logic [1:0] chg_r, chg_nxt;
  logic [15:0] watch;
  logic [15:0] diff;
  logic [1:0] chg_set;

  // Only unmasked input pins are watched; the others keep the baseline current.
  always_comb
  begin
    watch = dir_r & ~mask_r;
    diff = watch & (pins ^ ref_r);
    chg_set[0] = |diff[15:8];
    chg_set[1] = |diff[7:0];
    for (int i = 0; i < 16; i++)
    begin
      ref_nxt[i] = watch[i] ? ref_r[i] : pins[i];
    end
    if (rd_clr[0])
    begin
      ref_nxt[15:8] = pins.a;
    end
    if (rd_clr[1])
    begin
      ref_nxt[7:0] = pins.b;
    end
    // A clear retakes the snapshot from this cycle's levels, so the stale difference
    // must not keep the latch; any later change is caught against the new snapshot.
    chg_nxt = (chg_set | chg_r) & ~rd_clr;
  end

  // Detection state is cleared by power-on reset and by input reads, never by bus reset.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ref_r <= 16'h0000;
      chg_r <= 2'b00;
    end
    else if (!strap_done_r)
    begin
      ref_r <= pins;
      chg_r <= 2'b00;
    end
    else
    begin
      ref_r <= ref_nxt;
      chg_r <= chg_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  // Open-drain pins pull low only for a zero output; push-pull drive both levels.
  assign drain_group_pins_out = 8'h00;
  assign drain_group_pins_oe_out = ~dir_r.a & ~out_r.a;
  assign drive_group_pins_out = out_r.b;
  assign drive_group_pins_oe_out = ~dir_r.b;
  assign sda_out = 1'b0;
  assign sda_oe_out = sda_drv_r;
  assign interrupt_out_n_out = 1'b0;
  assign interrupt_oe_out = |chg_r;
  assign standby_out = (state_r == IOX_IDLE);

endmodule : iox_top

// file: testbench/i2c_io_expander_16bit_test.sv
// Self-checking bench for the 16-bit serial-bus I/O expander.
`timescale 1ns/10ps
`include "iox_regs.svh"
module i2c_io_expander_16bit_test
  import iox_pkg::*;
;
  logic core_clk_in, arst_n_in, bus_reset_n_in, addr_sel_0_in, addr_sel_1_in;
  logic scl, sda_low, sda, sda_oe, int_oe, standby, ak;
  logic [7:0] a_in, a_oe, b_in, b_out, b_oe, rd;
  logic [7:0] m_reg [8];
  iox_port_t ext;
  int failures, num_checks, cycles;
  int seed = 32'he33c82eb;

  // Pulled-up data line; pins show the device drive or the outside level.
  assign sda = !(sda_low || sda_oe);
  assign a_in = ~a_oe & ext.a;
  assign b_in = (b_oe & b_out) | (~b_oe & ext.b);

  iox_top dut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .scl_in(scl),
    .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe), .bus_reset_n_in(bus_reset_n_in),
    .addr_sel_0_in(addr_sel_0_in), .addr_sel_1_in(addr_sel_1_in),
    .drain_group_pins_in(a_in), .drain_group_pins_out(), .drain_group_pins_oe_out(a_oe),
    .drive_group_pins_in(b_in), .drive_group_pins_out(b_out),
    .drive_group_pins_oe_out(b_oe), .interrupt_out_n_out(), .interrupt_oe_out(int_oe),
    .standby_out(standby));
  iox_master_model m (.sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));

  // Core clock and the run-time ceiling.
  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      print_verdict();
    end
  end

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick

  // Expected pin levels from the model registers and the outside drive.
  function automatic logic [7:0] pin_exp(input logic grp);
    if (grp)
      return (~m_reg[5] & m_reg[3]) | (m_reg[5] & ext.b);
    return (m_reg[4] | m_reg[2]) & ext.a;
  endfunction : pin_exp

  // Start, own address for writing, then the register selector.
  task addr_sel(input logic [7:0] sel);
    m.bus_start();
    m.xfer({`IOX_ADDR_HI, addr_sel_1_in, addr_sel_0_in, 1'b0}, 1'b1, rd, ak);
    check(8'(ak), 8'h00);
    m.xfer(sel, 1'b1, rd, ak);
    check(8'(ak), 8'h00);
  endtask : addr_sel

  task wr_reg(input logic [7:0] sel, input logic [7:0] d);
    addr_sel(sel);
    m.xfer(d, 1'b1, rd, ak);
    check(8'(ak), 8'h00);
    m.bus_stop();
    if (sel >= 8'h02 && sel <= 8'h07)
      m_reg[sel[2:0]] = d;
    tick(2);
    check(a_in, pin_exp(1'b0));
    check(b_in, pin_exp(1'b1));
    check(b_oe, ~m_reg[5]);
  endtask : wr_reg

  // Read through selector, repeated start and a single byte ended by no-acknowledge.
  task rd_reg(input logic [7:0] sel);
    addr_sel(sel);
    m.bus_start();
    m.xfer({`IOX_ADDR_HI, addr_sel_1_in, addr_sel_0_in, 1'b1}, 1'b1, rd, ak);
    check(8'(ak), 8'h00);
    m.xfer(8'hff, 1'b1, rd, ak);
    m.bus_stop();
    check(rd, (sel < 8'h02) ? pin_exp(sel[0]) : m_reg[sel[2:0]]);
  endtask : rd_reg

  task expect_int(input logic v);
    tick(12);
    check(8'(int_oe), 8'(v));
  endtask : expect_int

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    arst_n_in = 1'b0;
    bus_reset_n_in = 1'b1;
    {addr_sel_1_in, addr_sel_0_in} = 2'h0;
    ext = '{a: 8'hff, b: 8'h00};
    // Power-up defaults under every strap setting.
    for (int s = 0; s < 4; s++)
    begin
      tick(1);
      arst_n_in = 1'b0;
      {addr_sel_1_in, addr_sel_0_in} = 2'(s);
      tick(10);
      arst_n_in = 1'b1;
      m_reg[2] = {{4{addr_sel_1_in}}, {4{addr_sel_0_in}}};
      m_reg[3] = m_reg[2];
      for (int r = 4; r < 8; r++)
        m_reg[r] = 8'h00;
      tick(20);
      check(8'(int_oe), 8'h00);
      check(8'(standby), 8'h01);
      check(a_in, pin_exp(1'b0));
      check(b_out, m_reg[3]);
      for (int r = 2; r < 8; r++)
        rd_reg(8'(r));
    end
    // With both straps high every open-drain pin powers up released.
    check(a_oe, 8'h00);
    $display("test done: power-up defaults");
    // Every single-bit miss of the address is ignored.
    for (int b = 0; b < 7; b++)
    begin
      m.bus_start();
      m.xfer({{`IOX_ADDR_HI, addr_sel_1_in, addr_sel_0_in} ^ 7'(1 << b), 1'b0}, 1'b1, rd, ak);
      check(8'(ak), 8'h01);
      m.xfer(8'h02, 1'b1, rd, ak);
      check(8'(ak), 8'h01);
      m.bus_stop();
    end
    $display("test done: foreign address");
    // Random register contents, an ignored input write, read-back of all.
    ext.b = 8'($random(seed));
    for (int r = 7; r >= 2; r--)
      wr_reg(8'(r), 8'($random(seed)));
    wr_reg(8'h00, 8'h5a);
    for (int r = 0; r < 8; r++)
      rd_reg(8'(r));
    expect_int(1'b0);
    $display("test done: registers");
    // Mask, turn to input, wait, unmask; then per-group latches.
    wr_reg(8'h07, 8'hff);
    wr_reg(8'h06, 8'hff);
    wr_reg(8'h05, 8'hff);
    wr_reg(8'h04, 8'hff);
    tick(10);
    wr_reg(8'h07, 8'h01);
    wr_reg(8'h06, 8'h00);
    expect_int(1'b0);
    ext.b[0] = ~ext.b[0];
    expect_int(1'b0);
    ext.a[3] = ~ext.a[3];
    expect_int(1'b1);
    rd_reg(8'h01);
    expect_int(1'b1);
    rd_reg(8'h00);
    expect_int(1'b0);
    ext.b[1] = ~ext.b[1];
    expect_int(1'b1);
    rd_reg(8'h00);
    expect_int(1'b1);
    rd_reg(8'h01);
    expect_int(1'b0);
    $display("test done: interrupt");
    // Output pins and output writes never raise the interrupt.
    wr_reg(8'h05, 8'h00);
    wr_reg(8'h03, ~m_reg[3]);
    wr_reg(8'h02, 8'h00);
    expect_int(1'b0);
    $display("test done: outputs quiet");
    // Bus reset in mid-read while the device pulls data low.
    ext.a[0] = ~ext.a[0];
    expect_int(1'b1);
    wr_reg(8'h03, 8'h00);
    addr_sel(8'h03);
    m.bus_start();
    m.xfer({`IOX_ADDR_HI, addr_sel_1_in, addr_sel_0_in, 1'b1}, 1'b1, rd, ak);
    m.pulse(1'b1, 120, ak);
    check(8'(ak), 8'h00);
    tick(1);
    bus_reset_n_in = 1'b0;
    tick(10);
    check(8'(sda_oe), 8'h00);
    check(8'(standby), 8'h01);
    check(8'(int_oe), 8'h01);
    bus_reset_n_in = 1'b1;
    tick(6);
    m.bus_stop();
    rd_reg(8'h03);
    rd_reg(8'h00);
    expect_int(1'b0);
    $display("test done: bus reset");
    print_verdict();
  end
endmodule : i2c_io_expander_16bit_test

// file: testbench/iox_master_model.sv
// Bus master model that clocks the serial bus for the expander bench.
`timescale 1ns/10ps
module iox_master_model (
  // Resolved data line.
  input wire logic sda_in,
  // Clock line and data pull-down.
  output logic scl_out,
  output logic sda_low_out
);
  // Long low phase ahead of bits the slave may change; normal half period.
  localparam int TSLOW = 120;
  localparam int THALF = 40;

  // Both lines idle released.
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // One pulse: change data in the low phase, sample at the end of the high phase.
  task pulse(input logic b, input int lo, output logic s);
    scl_out = 1'b0;
    #(lo / 2);
    sda_low_out = !b;
    #(lo - lo / 2);
    scl_out = 1'b1;
    #(THALF - 1);
    s = sda_in;
    #1;
  endtask : pulse

  // Start or repeated start: data falls while the clock is high.
  task bus_start;
    if (!(scl_out && sda_in))
    begin
      scl_out = 1'b0;
      #(TSLOW / 2);
      sda_low_out = 1'b0;
      #(TSLOW / 2);
      scl_out = 1'b1;
      #THALF;
    end
    sda_low_out = 1'b1;
    #THALF;
  endtask : bus_start

  // Stop: data rises while the clock is high; the clock then stands still.
  task bus_stop;
    scl_out = 1'b0;
    #(TSLOW / 2);
    sda_low_out = 1'b1;
    #(TSLOW / 2);
    scl_out = 1'b1;
    #THALF;
    sda_low_out = 1'b0;
    #THALF;
  endtask : bus_stop

  // One byte, most significant bit first, then the acknowledge clock.
  task xfer(input logic [7:0] tx, input logic nb, output logic [7:0] rx, output logic ab);
    for (int i = 7; i >= 0; i--)
    begin
      pulse(tx[i], (i == 7 || tx == 8'hff) ? TSLOW : THALF, rx[i]);
    end
    pulse(nb, TSLOW, ab);
  endtask : xfer
endmodule : iox_master_model

// file: testbench/iox_top_asserts.sv
// Concurrent checks on the pins of the 16-bit I/O expander.
`timescale 1ns/10ps
module iox_top_asserts (
  // Clock and power-on reset.
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Serial bus.
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // Bus reset and straps.
  input wire logic bus_reset_n_in,
  input wire logic addr_sel_0_in,
  input wire logic addr_sel_1_in,
  // Pin groups.
  input wire logic [7:0] drain_group_pins_in,
  input wire logic [7:0] drain_group_pins_out,
  input wire logic [7:0] drain_group_pins_oe_out,
  input wire logic [7:0] drive_group_pins_in,
  input wire logic [7:0] drive_group_pins_out,
  input wire logic [7:0] drive_group_pins_oe_out,
  // Interrupt and standby.
  input wire logic interrupt_out_n_out,
  input wire logic interrupt_oe_out,
  input wire logic standby_out
);
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  // Everything is sampled on the core clock and dropped while power-on reset is low.
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_sda_drain: assert property (sda_out == 1'b0 && interrupt_out_n_out == 1'b0)
    else $error("open-drain level driven high");
  a_strap_default: assert property ($rose(arst_n_in) |-> ##12
    drive_group_pins_out == {{4{addr_sel_1_in}}, {4{addr_sel_0_in}}} &&
    drain_group_pins_oe_out == ~{{4{addr_sel_1_in}}, {4{addr_sel_0_in}}})
    else $error("pin defaults do not follow the straps");
  a_abort_idle: assert property (!bus_reset_n_in [*8] |-> !sda_oe_out && standby_out)
    else $error("bus reset left the serial engine busy");
  a_abort_keeps_int: assert property (!bus_reset_n_in [*6] ##0 interrupt_oe_out |=>
    interrupt_oe_out)
    else $error("bus reset disturbed the interrupt");
  a_ack_stands: assert property ($rose(sda_oe_out) && bus_reset_n_in |-> sda_oe_out [*6])
    else $error("data pull-down released too early");
  a_drive_in_low: assert property ($changed(sda_oe_out) && bus_reset_n_in &&
    $past(bus_reset_n_in, 8) |-> !$past(scl_in, 2))
    else $error("data line changed outside the clock low phase");
  a_idle_quiet: assert property (standby_out |-> !sda_oe_out)
    else $error("data line pulled while idle");
  a_intr_cause: assert property ($rose(interrupt_oe_out) |->
    {$past(drain_group_pins_in, 3), $past(drive_group_pins_in, 3)} !=
    {$past(drain_group_pins_in, 9), $past(drive_group_pins_in, 9)})
    else $error("interrupt without a pin change");
  a_intr_release: assert property ($fell(interrupt_oe_out) |-> !standby_out)
    else $error("interrupt cleared outside a transfer");
endmodule : iox_top_asserts

bind iox_top iox_top_asserts u_chk (.*);
